// [dv/bdce_host.sv]
// Host model: shifts 17-bit frames over the serial debug link
`default_nettype none
module bdce_host (
  // Serial link
  output logic dsclk_o,
  output logic dsi_o,
  input wire logic dso_i
);
  timeunit 1ns;
  timeprecision 100ps;
  // Link clock idles low between frames
  initial begin
    dsclk_o = 1'h0;
    dsi_o = 1'h0;
  end
  // One frame MSB first; response bit sampled before each rise
  task automatic xfer(input logic [15:0] d, output logic [16:0] q);
    logic [16:0] f;
    f = {1'h0, d};
    for (int i = 16; i >= 0; i--) begin
      dsi_o = f[i];
      #62.5;
      q[i] = dso_i;
      dsclk_o = 1'h1;
      #62.5;
      dsclk_o = 1'h0;
    end
    // Released data line shows the inverse of the last bit
    dsi_o = ~f[0];
    #150;
  endtask
endmodule
`default_nettype wire

// [dv/bdce_top_bench.sv]
// Bench: bus and serial debug command sequences for the executor
`default_nettype none
module bdce_top_bench
  import bdce_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ======
  // Design connections and bench state
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic wb_cyc_i = 1'h0;
  logic wb_stb_i = 1'h0;
  logic wb_we_i = 1'h0;
  logic [3:0] wb_adr_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] mem_rdata_i = 32'h0;
  logic mem_ack_i = 1'h0;
  logic mem_err_i = 1'h0;
  logic [31:0] wb_dat_o, exc_fault_addr_o, return_counter_o, v, a;
  logic wb_ack_o, dsclk_i, dsi_i, dso_o, mem_valid_o, dbg_o, resume_o, exception_o;
  logic [15:0] status_word_o;
  logic [16:0] r;
  bdce_mem_req_s mem_o, last_req;
  int error_cnt = 0;
  int cmp_count = 0;
  int n_res = 0;
  int n_exc = 0;
  int mem_wait = 0;
  int slow = 2;
  int npoll = 0;
  logic [3:0] sels [10] = '{4'h0, 4'h1, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf};
  logic [1:0] dsz [3] = '{SZ_BYTE, SZ_LONG, SZ_WORD};
  always #2.5 clk_i = ~clk_i;
  bdce_top u_bdce_top (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dsclk_i(dsclk_i), .dsi_i(dsi_i),
    .dso_o(dso_o), .mem_valid_o(mem_valid_o), .mem_o(mem_o), .mem_rdata_i(mem_rdata_i),
    .mem_ack_i(mem_ack_i), .mem_err_i(mem_err_i), .background_debug_state_o(dbg_o),
    .resume_o(resume_o), .exception_o(exception_o), .exc_fault_addr_o(exc_fault_addr_o),
    .return_counter_o(return_counter_o), .status_word_o(status_word_o));
  bdce_host u_bdce_host (.dsclk_o(dsclk_i), .dsi_o(dsi_i), .dso_i(dso_o));
  // ======
  // Memory: slow + 1 wait cycles (three by default), faults in the top region, byte/word data replicated
  function automatic logic [31:0] rdat(input logic [31:0] x, input logic [1:0] z);
    logic [15:0] w;
    w = x[15:0] ^ 16'h5a5a;
    rdat = z == SZ_BYTE ? {4{w[7:0]}} : (z == SZ_WORD ? {2{w}} : {w, ~w});
  endfunction
  always @(posedge clk_i) begin
    mem_ack_i <= 1'h0;
    mem_err_i <= 1'h0;
    n_res <= n_res + int'(resume_o);
    n_exc <= n_exc + int'(exception_o);
    if (mem_valid_o && !mem_ack_i && !mem_err_i) begin
      mem_wait <= mem_wait + 1;
      if (mem_wait == slow) begin
        mem_wait <= 0;
        last_req <= mem_o;
        mem_ack_i <= mem_o.addr[31:28] != 4'hf;
        mem_err_i <= mem_o.addr[31:28] == 4'hf;
        mem_rdata_i <= rdat(mem_o.addr, mem_o.size);
      end
    end
  end
  // ======
  // Compare tasks and helpers
  task automatic chk_resp(input logic [16:0] got, input logic [16:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t response %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] att(input bdce_mem_req_s q);
    att = {26'h0, q.we, q.space, q.size};
  endfunction
  function automatic logic [31:0] inc(input logic [1:0] z);
    inc = z == SZ_LONG ? 32'h4 : (z == SZ_WORD ? 32'h2 : 32'h1);
  endfunction
  function automatic logic [31:0] sv(input logic [3:0] q);
    sv = {q, 12'habc, 4'h2, q, 4'h0, q};
  endfunction
  function automatic logic [31:0] exp_sr(input logic [3:0] q);
    logic [31:0] d;
    d = sv(q);
    case (q)
      SEL_FAULT: exp_sr = 32'h11223344;
      SEL_STATUS: exp_sr = {16'h0, d[15:0]};
      SEL_SRC, SEL_DST: exp_sr = {29'h0, d[2:0]};
      default: exp_sr = d;
    endcase
  endfunction
  // Classic single bus cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [3:0] x, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= x;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'h1);
    v = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    @(posedge clk_i);
  endtask
  task automatic sx(input logic [15:0] d);
    u_bdce_host.xfer(d, r);
  endtask
  task automatic sa(input logic [31:0] d);
    sx(d[31:16]);
    sx(d[15:0]);
  endtask
  task automatic poll();
    int n;
    n = 0;
    do begin
      sx(OP_NOP);
      n++;
    end while (r === RESP_NOT_READY && n < 8);
    npoll = n;
  endtask
  task automatic write_system_register_cmd(input logic [3:0] q, input logic [31:0] d);
    sx({OP_WRITE_SYSTEM_REGISTER_CMD, q});
    sa(d);
    poll();
    chk_resp(r, RESP_COMPLETE);
  endtask
  task automatic rd_cmd(input logic [7:0] op, input logic [1:0] z, input logic [31:0] x);
    logic [31:0] d;
    d = rdat(x, z);
    sx({op, z, 6'h0});
    if (op == OP_READ) sa(x);
    poll();
    chk_word(last_req.addr, x);
    chk_word(att(last_req), {26'h0, 4'h6, z});
    if (x[31:28] == 4'hf) begin
      chk_resp(r, RESP_FAULT);
    end else if (z == SZ_LONG) begin
      chk_resp(r, {1'h0, d[31:16]});
      sx(OP_NOP);
      chk_resp(r, {1'h0, d[15:0]});
    end else begin
      chk_resp(r, {1'h0, (z == SZ_BYTE ? {8'h0, d[7:0]} : d[15:0])});
    end
  endtask
  task automatic wr_cmd(input logic [7:0] op, input logic [1:0] z, input logic [31:0] x,
                        input logic [31:0] d);
    logic [31:0] m;
    m = z == SZ_LONG ? 32'hffffffff : (z == SZ_WORD ? 32'hffff : 32'hff);
    sx({op, z, 6'h0});
    if (op == OP_WRITE) sa(x);
    if (z == SZ_LONG) sa(d);
    else sx(d[15:0] & m[15:0]);
    poll();
    chk_word(last_req.addr, x);
    chk_word(att(last_req), {26'h0, 4'hf, z});
    chk_word(last_req.wdata & m, d & m);
    chk_resp(r, x[31:28] == 4'hf ? RESP_FAULT : RESP_COMPLETE);
  endtask
  task automatic conclude();
    $display("Errors %0d, comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Watchdog against a hung sequence
  initial begin
    #400000;
    error_cnt++;
    $display("[FAIL] %0t watchdog expired", $time);
    conclude();
  end
  // ======
  // Main sequence
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    chk_word({16'h0, status_word_o}, {16'h0, STATUS_RESET});
    wb(1'h0, ADDR_STAT, 32'h0);
    chk_word(v, 32'h0);
    wb(1'h0, 4'h2, 32'h0);
    chk_word(v, 32'h0);
    sx(OP_NOP);
    sx(OP_NOP);
    chk_resp(r, RESP_NOT_READY);
    wb(1'h1, ADDR_FAULT, 32'h11223344);
    wb(1'h1, ADDR_CTRL, 32'h1);
    chk_word({31'h0, dbg_o}, 32'h1);
    foreach (sels[i]) write_system_register_cmd(sels[i], sv(sels[i]));
    foreach (sels[i]) begin
      sx({OP_READ_SYSTEM_REGISTER_CMD, sels[i]});
      sx(OP_NOP);
      v = exp_sr(sels[i]);
      chk_resp(r, {1'h0, v[31:16]});
      sx(OP_NOP);
      chk_resp(r, {1'h0, v[15:0]});
    end
    chk_word({16'h0, status_word_o}, 32'h2b0b);
    wb(1'h0, ADDR_FAULT, 32'h0);
    chk_word(v, 32'h11223344);
    slow = 700;
    rd_cmd(OP_READ, SZ_WORD, 32'h100);
    slow = 2;
    chk_word(npoll, 32'h3);
    a = 32'h102;
    foreach (dsz[i]) begin
      sx(OP_NOP);
      rd_cmd(OP_DUMP, dsz[i], a);
      a = a + inc(dsz[i]);
    end
    rd_cmd(OP_READ, SZ_WORD, 32'hf0000000);
    rd_cmd(OP_DUMP, SZ_BYTE, 32'hf0000002);
    wr_cmd(OP_WRITE, SZ_LONG, 32'h200, 32'hcafe0001);
    a = 32'h204;
    foreach (dsz[i]) begin
      sx(OP_NOP);
      wr_cmd(OP_FILL, dsz[i], a, 32'h5a3c9617 ^ a);
      a = a + inc(dsz[i]);
    end
    wr_cmd(OP_WRITE, SZ_WORD, 32'hf0000010, 32'h1);
    wr_cmd(OP_FILL, SZ_BYTE, 32'hf0000012, 32'h2);
    sx(OP_RESUME);
    for (int k = 0; k < 100 && n_res == 0; k++) @(posedge clk_i);
    chk_word(n_res, 32'h1);
    chk_word(last_req.addr, 32'h0abc2000);
    chk_word(att(last_req), {26'h0, 4'h6, SZ_WORD});
    chk_word({31'h0, dbg_o}, 32'h0);
    wb(1'h1, ADDR_CTRL, 32'h1);
    write_system_register_cmd(SEL_RETURN, 32'hf0000401);
    write_system_register_cmd(SEL_STATUS, 32'h0);
    sx(OP_RESUME);
    for (int k = 0; k < 100 && n_exc == 0; k++) @(posedge clk_i);
    chk_word(n_exc, 32'h1);
    chk_word(exc_fault_addr_o, 32'hf0000401);
    chk_word(att(last_req), {26'h0, 4'h2, SZ_WORD});
    chk_word({31'h0, dbg_o}, 32'h0);
    chk_word(n_res, 32'h1);
    conclude();
  end
endmodule
`default_nettype wire

// [dv/bdce_top_sva.sv]
// Checker: port-level properties of the debug command executor
`default_nettype none
module bdce_checker
  import bdce_pkg::*;
(
  // Observed ports
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic mem_valid_o,
  input wire bdce_pkg::bdce_mem_req_s mem_o,
  input wire logic mem_ack_i,
  input wire logic mem_err_i,
  input wire logic background_debug_state_o,
  input wire logic resume_o,
  input wire logic exception_o,
  input wire logic [31:0] exc_fault_addr_o,
  input wire logic [31:0] return_counter_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ======
  // Completion steps of a memory access
  sequence s_done;
    mem_valid_o && (mem_ack_i || mem_err_i);
  endsequence
  sequence s_fault;
    mem_valid_o && mem_err_i;
  endsequence
  // Bus answer timing and idle read data
  a_ack_single: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack is not a single cycle answer");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data shown outside ack");
  // Memory request holds until completion, then drops
  a_mem_hold: assert property (
    mem_valid_o && !mem_ack_i && !mem_err_i |=> mem_valid_o && $stable(mem_o))
    else $error("memory request changed before completion");
  a_mem_release: assert property (s_done |=> !mem_valid_o)
    else $error("memory request held after completion");
  a_mem_debug: assert property ($rose(mem_valid_o) |-> background_debug_state_o)
    else $error("memory access started outside debug mode");
  // Resume and prefetch fault outcomes
  a_resume_cause: assert property (
    resume_o |-> $past(mem_ack_i) && $past(mem_o.addr) == return_counter_o)
    else $error("resume without prefetch at return counter");
  a_resume_exit: assert property (resume_o |=> !resume_o && !background_debug_state_o)
    else $error("debug mode kept after resume");
  a_exc_cause: assert property (
    exception_o |-> $past(mem_err_i) && exc_fault_addr_o == return_counter_o)
    else $error("exception without fault or wrong fault address");
  a_exc_exit: assert property (s_fault ##1 exception_o |=> !background_debug_state_o)
    else $error("debug mode kept after prefetch fault");
  a_fault_quiet: assert property (s_fault |=> !resume_o)
    else $error("resume reported after a fault");
endmodule
bind bdce_top bdce_checker u_bdce_checker (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .mem_valid_o(mem_valid_o), .mem_o(mem_o),
  .mem_ack_i(mem_ack_i), .mem_err_i(mem_err_i),
  .background_debug_state_o(background_debug_state_o), .resume_o(resume_o),
  .exception_o(exception_o), .exc_fault_addr_o(exc_fault_addr_o),
  .return_counter_o(return_counter_o)
);
`default_nettype wire

// [hdl/bdce_pkg.sv]
// Package: constants, encodings and carriers of the debug command executor
`default_nettype none
package bdce_pkg;
  // ==========================================================
  // Serial responses (17 bits: status bit then data word)
  localparam logic [16:0] RESP_NOT_READY = 17'h10000;
  localparam logic [16:0] RESP_COMPLETE = 17'h0ffff;
  localparam logic [16:0] RESP_FAULT = 17'h10001;
  localparam logic [16:0] RESP_ILLEGAL = 17'h1ffff;
  localparam logic [4:0] FRAME_LAST = 5'h10;
  // ==========================================================
  // Opcode fields
  localparam logic [7:0] OP_READ = 8'h19;
  localparam logic [7:0] OP_WRITE = 8'h18;
  localparam logic [7:0] OP_DUMP = 8'h1d;
  localparam logic [7:0] OP_FILL = 8'h1c;
  localparam logic [15:0] OP_RESUME = 16'h0c00;
  localparam logic [15:0] OP_NOP = 16'h0000;
  localparam logic [11:0] OP_WRITE_SYSTEM_REGISTER_CMD = 12'h248;
  localparam logic [11:0] OP_READ_SYSTEM_REGISTER_CMD = 12'h258;
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;
  // ==========================================================
  // System register select codes
  localparam logic [3:0] SEL_RETURN = 4'h0;
  localparam logic [3:0] SEL_CURRENT = 4'h1;
  localparam logic [3:0] SEL_SCRATCH = 4'h8;
  localparam logic [3:0] SEL_FAULT = 4'h9;
  localparam logic [3:0] SEL_VECBASE = 4'ha;
  localparam logic [3:0] SEL_STATUS = 4'hb;
  localparam logic [3:0] SEL_USP = 4'hc;
  localparam logic [3:0] SEL_SSP = 4'hd;
  localparam logic [3:0] SEL_SRC = 4'he;
  localparam logic [3:0] SEL_DST = 4'hf;
  localparam int STATUS_SUPER_BIT = 13;
  localparam logic [2:0] SPACE_USER_PROG = 3'h2;
  localparam logic [2:0] SPACE_SUPER_PROG = 3'h6;
  // ==========================================================
  // Wishbone register map and reset values
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h4;
  localparam logic [3:0] ADDR_RETURN = 4'h8;
  localparam logic [3:0] ADDR_FAULT = 4'hc;
  localparam logic [15:0] STATUS_RESET = 16'h2700;
  // ==========================================================
  // Memory access carrier
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [1:0] size;
    logic [2:0] space;
    logic we;
  } bdce_mem_req_s;
  typedef enum logic [3:0] {
    ST_CMD = 4'h0,
    ST_ADDR_HI = 4'h1,
    ST_ADDR_LO = 4'h2,
    ST_DATA_HI = 4'h3,
    ST_DATA_LO = 4'h4,
    ST_MEM = 4'h5,
    ST_HOLD = 4'h6,
    ST_RES_LO = 4'h7,
    ST_FETCH = 4'h8
  } bdce_state_e;
  typedef enum logic [2:0] {
    K_READ = 3'h0,
    K_WRITE = 3'h1,
    K_DUMP = 3'h2,
    K_FILL = 3'h3,
    K_WRITE_SYSTEM_REGISTER_CMD = 3'h4
  } bdce_kind_e;
endpackage
`default_nettype wire

// [hdl/bdce_top.sv]
// Module: serial background debug command executor with Wishbone control
// Summary of operation
// - Four-bit selector picks the system register
// - Register write reaches all supervisor-writable registers
// - Operand is 32 bits; narrow targets take low word
// - Register write answers with command complete
// - Fault address ignores debug port writes
// - Memory read uses source space, sized access
// - Byte/word results in a word, long in two
// - Read success clears bit 16; fault gives 10001
// - Memory write uses destination space, sized access
// - Write success 0FFFF; fault gives 10001
// - Read stores address plus size; dump advances
// - No-operation leaves the block pointer alone
// - Size field decoded on every block command
// - Dump returns data and status like read
// - Write stores address plus size; fill advances
// - Fill returns 0FFFF or 10001
// - Resume prefetches at return counter, current privilege
// - Prefetch fault leaves debug, raises exception
// - Register read returns 32 zero-extended bits
// - Frames during memory access answer not ready
//
// The placing of the registers and the Wishbone slave port were left to the implementer.
`default_nettype none
module bdce_top
  import bdce_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Serial debug link
  input wire logic dsclk_i,
  input wire logic dsi_i,
  output logic dso_o,
  // Processor memory port
  output logic mem_valid_o,
  output bdce_pkg::bdce_mem_req_s mem_o,
  input wire logic [31:0] mem_rdata_i,
  input wire logic mem_ack_i,
  input wire logic mem_err_i,
  // Processor state
  output logic background_debug_state_o,
  output logic resume_o,
  output logic exception_o,
  output logic [31:0] exc_fault_addr_o,
  output logic [31:0] return_counter_o,
  output logic [15:0] status_word_o
);
  import bdce_pkg::*;

  // ==========================================================
  // Link synchronisers and edge detection
  logic clk_meta, clk_sync, clk_prev, din_meta, din_sync;
  logic lk_rise;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_meta <= 1'b0;
      clk_sync <= 1'b0;
      clk_prev <= 1'b0;
      din_meta <= 1'b0;
      din_sync <= 1'b0;
    end else begin
      clk_meta <= dsclk_i;
      clk_sync <= clk_meta;
      clk_prev <= clk_sync;
      din_meta <= dsi_i;
      din_sync <= din_meta;
    end
  end
  assign lk_rise = clk_sync & ~clk_prev;

  // ==========================================================
  // System registers and command state
  logic [31:0] return_counter, current_instr_counter, scratch_address_reg;
  logic [31:0] fault_address_reg, vector_table_base, user_stack_ptr;
  logic [31:0] supervisor_stack_ptr;
  logic [15:0] status_word;
  logic [2:0] source_space_code, dest_space_code;
  logic [16:0] rx, tx;
  logic [4:0] bit_cnt;
  logic frame_done;
  bdce_state_e state;
  bdce_kind_e kind;
  logic [1:0] size;
  logic [3:0] reg_sel;
  logic [31:0] addr, data, ptr;
  logic [16:0] pend_resp;
  logic [15:0] pend_lo;
  logic pend_long;
  logic debug_on;
  logic [15:0] word;
  logic [31:0] size_bytes, sel_value, size_bytes_new;
  logic wb_hit;

  assign word = rx[15:0];
  assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  // Byte count of a size code
  function automatic logic [31:0] bytes_of(input logic [1:0] sz);
    bytes_of = (sz == SZ_BYTE) ? 32'h1 : (sz == SZ_WORD) ? 32'h2 : 32'h4;
  endfunction

  // Size of the access under way and of the incoming command
  assign size_bytes = bytes_of(size);
  assign size_bytes_new = bytes_of(word[7:6]);

  // Register read selection, zero-extended
  always_comb begin
    case (word[3:0])
      SEL_RETURN: sel_value = return_counter;
      SEL_CURRENT: sel_value = current_instr_counter;
      SEL_SCRATCH: sel_value = scratch_address_reg;
      SEL_FAULT: sel_value = fault_address_reg;
      SEL_VECBASE: sel_value = vector_table_base;
      SEL_STATUS: sel_value = {16'h0000, status_word};
      SEL_USP: sel_value = user_stack_ptr;
      SEL_SSP: sel_value = supervisor_stack_ptr;
      SEL_SRC: sel_value = {29'h0, source_space_code};
      SEL_DST: sel_value = {29'h0, dest_space_code};
      default: sel_value = 32'h0;
    endcase
  end

  // ==========================================================
  // Frame shifter: 17 bits in and out per frame
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx <= 17'h0;
      bit_cnt <= 5'h0;
      frame_done <= 1'b0;
    end else begin
      frame_done <= 1'b0;
      if (lk_rise) begin
        rx <= {rx[15:0], din_sync};
        if (bit_cnt == FRAME_LAST) begin
          bit_cnt <= 5'h0;
          frame_done <= 1'b1;
        end else begin
          bit_cnt <= bit_cnt + 5'h1;
        end
      end
    end
  end
  assign dso_o = tx[16];

  // ==========================================================
  // Command sequencer, responses and register updates
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_CMD;
      kind <= K_READ;
      size <= SZ_BYTE;
      reg_sel <= 4'h0;
      addr <= 32'h0;
      data <= 32'h0;
      ptr <= 32'h0;
      tx <= RESP_NOT_READY;
      pend_resp <= RESP_NOT_READY;
      pend_lo <= 16'h0;
      pend_long <= 1'b0;
      mem_valid_o <= 1'b0;
      mem_o <= '0;
      resume_o <= 1'b0;
      exception_o <= 1'b0;
      exc_fault_addr_o <= 32'h0;
      return_counter <= 32'h0;
      current_instr_counter <= 32'h0;
      scratch_address_reg <= 32'h0;
      vector_table_base <= 32'h0;
      user_stack_ptr <= 32'h0;
      supervisor_stack_ptr <= 32'h0;
      status_word <= STATUS_RESET;
      source_space_code <= 3'h0;
      dest_space_code <= 3'h0;
    end else begin
      resume_o <= 1'b0;
      exception_o <= 1'b0;
      if (lk_rise) begin
        tx <= {tx[15:0], 1'b0};
      end
      if (frame_done && !debug_on) begin
        tx <= RESP_NOT_READY;
      end else if (frame_done) begin
        case (state)
          ST_CMD: begin
            tx <= RESP_NOT_READY;
            if (word[15:8] == OP_READ && word[5:0] == 6'h0) begin
              kind <= K_READ;
              size <= word[7:6];
              state <= ST_ADDR_HI;
            end else if (word[15:8] == OP_WRITE && word[5:0] == 6'h0) begin
              kind <= K_WRITE;
              size <= word[7:6];
              state <= ST_ADDR_HI;
            end else if (word[15:8] == OP_DUMP && word[5:0] == 6'h0) begin
              // Pointer read and advanced with the fresh size
              mem_o <= '{addr: ptr, wdata: 32'h0, size: word[7:6],
                         space: source_space_code, we: 1'b0};
              mem_valid_o <= 1'b1;
              ptr <= ptr + size_bytes_new;
              kind <= K_DUMP;
              size <= word[7:6];
              state <= ST_MEM;
            end else if (word[15:8] == OP_FILL && word[5:0] == 6'h0) begin
              kind <= K_FILL;
              size <= word[7:6];
              state <= (word[7:6] == SZ_LONG) ? ST_DATA_HI : ST_DATA_LO;
            end else if (word[15:4] == OP_WRITE_SYSTEM_REGISTER_CMD) begin
              kind <= K_WRITE_SYSTEM_REGISTER_CMD;
              reg_sel <= word[3:0];
              state <= ST_DATA_HI;
            end else if (word[15:4] == OP_READ_SYSTEM_REGISTER_CMD) begin
              tx <= {1'b0, sel_value[31:16]};
              pend_lo <= sel_value[15:0];
              state <= ST_RES_LO;
            end else if (word == OP_RESUME) begin
              // Prefetch at return counter in current privilege
              mem_o <= '{addr: return_counter, wdata: 32'h0, size: SZ_WORD,
                         space: status_word[STATUS_SUPER_BIT] ? SPACE_SUPER_PROG
                                                              : SPACE_USER_PROG,
                         we: 1'b0};
              mem_valid_o <= 1'b1;
              state <= ST_FETCH;
            end else if (word == OP_NOP) begin
              tx <= RESP_COMPLETE;
            end else begin
              tx <= RESP_ILLEGAL;
            end
          end
          ST_ADDR_HI: begin
            tx <= RESP_NOT_READY;
            addr[31:16] <= word;
            state <= ST_ADDR_LO;
          end
          ST_ADDR_LO: begin
            tx <= RESP_NOT_READY;
            addr[15:0] <= word;
            if (kind == K_READ) begin
              mem_o <= '{addr: {addr[31:16], word}, wdata: 32'h0, size: size,
                         space: source_space_code, we: 1'b0};
              mem_valid_o <= 1'b1;
              ptr <= {addr[31:16], word} + size_bytes;
              state <= ST_MEM;
            end else begin
              ptr <= {addr[31:16], word} + size_bytes;
              state <= (size == SZ_LONG) ? ST_DATA_HI : ST_DATA_LO;
            end
          end
          ST_DATA_HI: begin
            tx <= RESP_NOT_READY;
            data[31:16] <= word;
            state <= ST_DATA_LO;
          end
          ST_DATA_LO: begin
            if (kind == K_WRITE_SYSTEM_REGISTER_CMD) begin
              tx <= RESP_COMPLETE;
              state <= ST_CMD;
              case (reg_sel)
                SEL_RETURN: return_counter <= {data[31:16], word};
                SEL_CURRENT: current_instr_counter <= {data[31:16], word};
                SEL_SCRATCH: scratch_address_reg <= {data[31:16], word};
                SEL_VECBASE: vector_table_base <= {data[31:16], word};
                SEL_STATUS: status_word <= word;
                SEL_USP: user_stack_ptr <= {data[31:16], word};
                SEL_SSP: supervisor_stack_ptr <= {data[31:16], word};
                SEL_SRC: source_space_code <= word[2:0];
                SEL_DST: dest_space_code <= word[2:0];
                default: ; // Fault address stays as it is
              endcase
            end else begin
              tx <= RESP_NOT_READY;
              mem_o <= '{addr: (kind == K_FILL) ? ptr : addr,
                         wdata: (size == SZ_LONG) ? {data[31:16], word}
                              : (size == SZ_WORD) ? {16'h0, word}
                              : {24'h0, word[7:0]},
                         size: size, space: dest_space_code, we: 1'b1};
              mem_valid_o <= 1'b1;
              if (kind == K_FILL) begin
                ptr <= ptr + size_bytes;
              end
              state <= ST_MEM;
            end
          end
          ST_RES_LO: begin
            tx <= {1'b0, pend_lo};
            state <= ST_CMD;
          end
          default: begin
            tx <= RESP_NOT_READY;
          end
        endcase
      end
      // Memory completion: park the answer until the link is between frames
      if (state == ST_MEM && (mem_ack_i || mem_err_i)) begin
        mem_valid_o <= 1'b0;
        pend_long <= 1'b0;
        state <= ST_HOLD;
        if (mem_err_i) begin
          pend_resp <= RESP_FAULT;
        end else if (mem_o.we) begin
          pend_resp <= RESP_COMPLETE;
        end else if (size == SZ_LONG) begin
          pend_resp <= {1'b0, mem_rdata_i[31:16]};
          pend_lo <= mem_rdata_i[15:0];
          pend_long <= 1'b1;
        end else if (size == SZ_WORD) begin
          pend_resp <= {1'b0, mem_rdata_i[15:0]};
        end else begin
          pend_resp <= {9'h0, mem_rdata_i[7:0]};
        end
      end
      if (state == ST_HOLD && bit_cnt == 5'h0 && !frame_done && !lk_rise) begin
        tx <= pend_resp;
        state <= pend_long ? ST_RES_LO : ST_CMD;
      end
      // Resume prefetch outcome
      if (state == ST_FETCH && (mem_ack_i || mem_err_i)) begin
        mem_valid_o <= 1'b0;
        state <= ST_CMD;
        tx <= RESP_NOT_READY;
        if (mem_err_i) begin
          exception_o <= 1'b1;
          exc_fault_addr_o <= return_counter;
        end else begin
          resume_o <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Debug state: entered by software, left on resume or prefetch fault
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      debug_on <= 1'b0;
    end else if (state == ST_FETCH && (mem_ack_i || mem_err_i)) begin
      debug_on <= 1'b0;
    end else if (wb_hit && wb_we_i && wb_adr_i == ADDR_CTRL && wb_sel_i[0]) begin
      debug_on <= wb_dat_i[0];
    end
  end

  // ==========================================================
  // Fault address, loaded only by the processor side over Wishbone
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_address_reg <= 32'h0;
    end else if (wb_hit && wb_we_i && wb_adr_i == ADDR_FAULT) begin
      for (int i = 0; i < 4; i++) begin
        if (wb_sel_i[i]) begin
          fault_address_reg[i*8 +: 8] <= wb_dat_i[i*8 +: 8];
        end
      end
    end
  end

  // ==========================================================
  // Wishbone answer: one cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= 32'h0;
      if (wb_hit && !wb_we_i) begin
        case (wb_adr_i)
          ADDR_CTRL: wb_dat_o <= {31'h0, debug_on};
          ADDR_STAT: wb_dat_o <= {28'h0, state};
          ADDR_RETURN: wb_dat_o <= return_counter;
          ADDR_FAULT: wb_dat_o <= fault_address_reg;
          default: wb_dat_o <= 32'h0;
        endcase
      end
    end
  end

  // State visible to the processor
  assign background_debug_state_o = debug_on;
  assign return_counter_o = return_counter;
  assign status_word_o = status_word;
endmodule
`default_nettype wire
